/* File: chsg_div.sv */
`timescale 1ns/10ps
// restoring divider, one quotient bit per clock
module chsg_div (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic [31:0] dividend_in,
	input  wire logic [15:0] divisor_in,
	output logic             done_out,
	output logic [31:0]      quotient_out
);
	logic [31:0] dvd_reg;
	logic [15:0] dvs_reg;
	logic [16:0] rem_reg;
	logic [5:0]  cnt_reg;
	logic        done_reg;
	logic [16:0] rem_sh;
	logic        fits;

	// trial subtract of the shifted partial remainder
	assign rem_sh       = {rem_reg[15:0], dvd_reg[31]};
	assign fits         = rem_sh >= {1'b0, dvs_reg};
	assign done_out     = done_reg;
	assign quotient_out = dvd_reg;

	// quotient bits shift into the dividend register
	always_ff @(posedge clk_in) begin
		done_reg <= 1'b0;
		if (rst_in) begin
			dvd_reg <= 32'h00000000;
			dvs_reg <= 16'h0000;
			rem_reg <= 17'h00000;
			cnt_reg <= 6'h00;
		end else if (start_in) begin
			dvd_reg <= dividend_in;
			dvs_reg <= divisor_in;
			rem_reg <= 17'h00000;
			cnt_reg <= chsg_pkg::DIV_STEPS;
		end else if (cnt_reg != 6'h00) begin
			rem_reg <= fits ? rem_sh - {1'b0, dvs_reg} : rem_sh;
			dvd_reg <= {dvd_reg[30:0], fits};
			cnt_reg <= cnt_reg - 6'h01;
			done_reg <= (cnt_reg == 6'h01);
		end
	end
endmodule : chsg_div

/* File: chsg_geometry.sv */
`timescale 1ns/10ps
// identification geometry words: defaults (1,3,6) and current (53-58)
module chsg_geometry (
	input  wire logic                MCLK_IN,
	input  wire logic                SYS_RST_IN,
	input  wire logic [31:0]         TOTAL_SECTORS_IN,
	input  wire logic                INIT_STB_IN,
	input  wire chsg_pkg::chsg_init_t INIT_PARAMS_IN,
	output chsg_pkg::chsg_geom_t     DEF_GEOM_OUT,
	output chsg_pkg::chsg_geom_t     CUR_GEOM_OUT,
	output logic [15:0]              WORD53_OUT,
	output logic [31:0]              CAPACITY_OUT,
	output logic                     BUSY_OUT
);
	typedef enum logic [2:0] {
		ST_START,
		ST_DEF_WAIT,
		ST_DEF_SET,
		ST_IDLE,
		ST_CUR_WAIT,
		ST_CUR_SET
	} chsg_state_t;

	chsg_state_t          state_reg;
	chsg_state_t          state_next;
	chsg_pkg::chsg_geom_t def_reg;
	chsg_pkg::chsg_geom_t cur_reg;
	logic                 valid_reg;
	logic [31:0]          cap_reg;
	logic                 busy_reg;
	logic [31:0]          total_reg;
	logic [4:0]           req_heads_reg;
	logic [7:0]           req_sect_reg;
	logic [15:0]          cyl_tmp_reg;
	logic                 div_start_reg;
	logic [15:0]          div_dvs_reg;

	logic                 div_done;
	logic [31:0]          div_q;
	logic [15:0]          q_sat;
	logic                 small_dev;
	logic [15:0]          big_cap;
	logic [15:0]          def_cyl;
	logic [12:0]          req_per_cyl;
	logic                 req_ok;
	logic [28:0]          cap_prod;
	logic                 init_take;
	logic                 init_good;
	logic                 init_bad;
	logic                 job_start;
	logic                 def_set;
	logic                 cur_set;

	// one divider serves both jobs; 32 serial steps trade latency
	// for area, harmless since the host waits on busy anyway
	chsg_div u_div (
		.clk_in      (MCLK_IN),
		.rst_in      (SYS_RST_IN),
		.start_in    (div_start_reg),
		.dividend_in (total_reg),
		.divisor_in  (div_dvs_reg),
		.done_out    (div_done),
		.quotient_out(div_q)
	);

	// quotient clamped to one word
	// beyond the clamp the spare sectors are simply left over
	assign q_sat = (div_q[31:16] != 16'h0000) ? chsg_pkg::WORD_MAX
	                                          : div_q[15:0];

	// default cylinder limit picked from the total size and the default head count
	// the same quotient feeds both limits; only one is picked
	assign small_dev = total_reg <= chsg_pkg::SMALL_SECTORS;
	assign big_cap = (chsg_pkg::DEF_HEADS <= chsg_pkg::HEADS_FEW_LIM) ?
	                 chsg_pkg::CAP_FEW_HEADS :
	                 (chsg_pkg::DEF_HEADS <= chsg_pkg::HEADS_MID_LIM) ?
	                 chsg_pkg::CAP_MID_HEADS : chsg_pkg::CAP_MANY_HEADS;
	assign def_cyl = small_dev ?
	                 ((q_sat > chsg_pkg::SMALL_CYL_MAX) ?
	                  chsg_pkg::SMALL_CYL_MAX : q_sat) :
	                 ((q_sat > big_cap) ? big_cap : q_sat);

	// a zero count or more than sixteen heads cannot be translated
	// the sector field is eight bits, so its upper bound is free
	assign req_ok = (INIT_PARAMS_IN.heads != 5'h00) &&
	                (INIT_PARAMS_IN.heads <= chsg_pkg::CUR_HEADS_MAX) &&
	                (INIT_PARAMS_IN.sectors != 8'h00);
	assign req_per_cyl = 13'(INIT_PARAMS_IN.heads) *
	                     13'(INIT_PARAMS_IN.sectors);

	// floor division keeps the product at or below the total
	assign cap_prod = 29'(cyl_tmp_reg) * 29'(div_dvs_reg[12:0]);

	// a strobe counts only while idle; one that lands mid-job is dropped
	// so the host never sees half-updated words
	assign init_take = (state_reg == ST_IDLE) && INIT_STB_IN;
	assign init_good = init_take && req_ok;
	assign init_bad  = init_take && !req_ok;

	// state decodes shared by the update processes
	assign job_start = (state_reg == ST_START);
	assign def_set   = (state_reg == ST_DEF_SET);
	assign cur_set   = (state_reg == ST_CUR_SET);

	assign DEF_GEOM_OUT = def_reg;
	assign CUR_GEOM_OUT = cur_reg;
	assign WORD53_OUT   = {15'h0000, valid_reg};
	assign CAPACITY_OUT = cap_reg;
	assign BUSY_OUT     = busy_reg;

	// sequencing of the two division jobs
	// a refused strobe leaves the machine idle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_START:    state_next = ST_DEF_WAIT;
			ST_DEF_WAIT: if (div_done) begin
				state_next = ST_DEF_SET;
			end
			ST_DEF_SET:  state_next = ST_IDLE;
			ST_IDLE:     if (INIT_STB_IN && req_ok) begin
				state_next = ST_CUR_WAIT;
			end
			ST_CUR_WAIT: if (div_done) begin
				state_next = ST_CUR_SET;
			end
			ST_CUR_SET:  state_next = ST_IDLE;
			default:     state_next = ST_START;
		endcase
	end

	// state register; reset restarts the default job
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= ST_START;
		end else begin
			state_reg <= state_next;
		end
	end

	// divider launch; total is caught once after reset release
	// later changes of the total wait for the next reset
	always_ff @(posedge MCLK_IN) begin
		div_start_reg <= 1'b0;
		if (SYS_RST_IN) begin
			total_reg   <= 32'h00000000;
			div_dvs_reg <= 16'h0000;
		end else if (job_start) begin
			total_reg     <= TOTAL_SECTORS_IN;
			div_dvs_reg   <= 16'(chsg_pkg::DEF_HEADS * chsg_pkg::DEF_SECTORS);
			div_start_reg <= 1'b1;
		end else if (init_good) begin
			div_dvs_reg   <= {3'h0, req_per_cyl};
			div_start_reg <= 1'b1;
		end
	end

	// request latch and the quotient held until the joint update
	// bad params are latched too; only a good job ever reads them
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			req_heads_reg <= 5'h00;
			req_sect_reg  <= 8'h00;
			cyl_tmp_reg   <= 16'h0000;
		end else begin
			if (init_take) begin
				req_heads_reg <= INIT_PARAMS_IN.heads;
				req_sect_reg  <= INIT_PARAMS_IN.sectors;
			end
			if (div_done) begin
				cyl_tmp_reg <= (state_reg == ST_DEF_WAIT) ? def_cyl : q_sat;
			end
		end
	end

	// default words: written once, never again until reset
	// holding them keeps host tables steady for the whole session
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			def_reg <= '0;
		end else if (def_set) begin
			def_reg.cylinders <= cyl_tmp_reg;
			def_reg.heads     <= chsg_pkg::DEF_HEADS;
			def_reg.sectors   <= chsg_pkg::DEF_SECTORS;
		end
	end

	// current words 53-58 always change as one set
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			cur_reg   <= '0;
			cap_reg   <= 32'h00000000;
			valid_reg <= 1'b0;
		end else if (def_set) begin
			cur_reg.cylinders <= cyl_tmp_reg;
			cur_reg.heads     <= chsg_pkg::DEF_HEADS;
			cur_reg.sectors   <= chsg_pkg::DEF_SECTORS;
			cap_reg           <= {3'h0, cap_prod};
			valid_reg         <= 1'b1;
		end else if (init_bad) begin
			// words 54-58 read zero until a good job lands
			cur_reg   <= '0;
			cap_reg   <= 32'h00000000;
			valid_reg <= 1'b0;
		end else if (cur_set) begin
			cur_reg.cylinders <= cyl_tmp_reg;
			cur_reg.heads     <= {11'h000, req_heads_reg};
			cur_reg.sectors   <= {8'h00, req_sect_reg};
			cap_reg           <= {3'h0, cap_prod};
			valid_reg         <= 1'b1;
		end
	end

	// busy covers every cycle the words are not settled
	// taken from state_next so busy and the words move on one edge
	always_ff @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			busy_reg <= 1'b1;
		end else begin
			busy_reg <= (state_next != ST_IDLE);
		end
	end
endmodule : chsg_geometry

/* File: chsg_geometry_sva.sv */
`timescale 1ns/10ps
// watches the geometry words at the top ports
module chsg_geometry_sva (
	input wire logic                 MCLK_IN,
	input wire logic                 SYS_RST_IN,
	input wire logic [31:0]          TOTAL_SECTORS_IN,
	input wire logic                 INIT_STB_IN,
	input wire chsg_pkg::chsg_init_t INIT_PARAMS_IN,
	input wire chsg_pkg::chsg_geom_t DEF_GEOM_OUT,
	input wire chsg_pkg::chsg_geom_t CUR_GEOM_OUT,
	input wire logic [15:0]          WORD53_OUT,
	input wire logic [31:0]          CAPACITY_OUT,
	input wire logic                 BUSY_OUT
);
	default clocking @(posedge MCLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	// accepted request, its legality, and the full-width product
	wire logic acc = INIT_STB_IN && !BUSY_OUT;
	wire logic ok = INIT_PARAMS_IN.heads inside {[5'h01:5'h10]} &&
		INIT_PARAMS_IN.sectors != 8'h00;
	wire logic [47:0] vol = CUR_GEOM_OUT.cylinders *
		CUR_GEOM_OUT.heads * CUR_GEOM_OUT.sectors;
	property p_small;
		!BUSY_OUT && TOTAL_SECTORS_IN <= chsg_pkg::SMALL_SECTORS |->
			DEF_GEOM_OUT.cylinders <= chsg_pkg::SMALL_CYL_MAX;
	endproperty
	a_small: assert property (p_small) else $error("small cap");
	property p_fixed;
		!BUSY_OUT && !$past(BUSY_OUT) |->
			$stable(DEF_GEOM_OUT) && DEF_GEOM_OUT.heads <= 16'h0010;
	endproperty
	a_fixed: assert property (p_fixed) else $error("default moved");
	property p_valid;
		!BUSY_OUT && CUR_GEOM_OUT.heads != 16'h0000 |-> WORD53_OUT == 16'h0001;
	endproperty
	a_valid: assert property (p_valid) else $error("valid bit");
	property p_bad;
		acc && !ok |=> !BUSY_OUT && WORD53_OUT == 16'h0000 &&
			CUR_GEOM_OUT == '0 && CAPACITY_OUT == 32'h0;
	endproperty
	a_bad: assert property (p_bad) else $error("bad mode");
	property p_busy;
		acc && ok |=> BUSY_OUT ##35 !BUSY_OUT;
	endproperty
	a_busy: assert property (p_busy) else $error("busy span");
	property p_take;
		acc && ok |-> ##36 CUR_GEOM_OUT.heads[4:0] == $past(INIT_PARAMS_IN.heads,
			36) && CUR_GEOM_OUT.sectors[7:0] == $past(INIT_PARAMS_IN.sectors, 36);
	endproperty
	a_take: assert property (p_take) else $error("params");
	property p_prod;
		!BUSY_OUT |-> {16'h0000, CAPACITY_OUT} == vol;
	endproperty
	a_prod: assert property (p_prod) else $error("capacity");
	property p_cap;
		!BUSY_OUT |-> CAPACITY_OUT <= TOTAL_SECTORS_IN;
	endproperty
	a_cap: assert property (p_cap) else $error("over total");
	c_good: cover property (acc && ok);
	c_bad: cover property (acc && !ok);
	c_ready: cover property ($fell(BUSY_OUT));
endmodule : chsg_geometry_sva

bind chsg_geometry chsg_geometry_sva u_sva (.MCLK_IN(MCLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .TOTAL_SECTORS_IN(TOTAL_SECTORS_IN),
	.INIT_STB_IN(INIT_STB_IN), .INIT_PARAMS_IN(INIT_PARAMS_IN),
	.DEF_GEOM_OUT(DEF_GEOM_OUT), .CUR_GEOM_OUT(CUR_GEOM_OUT),
	.WORD53_OUT(WORD53_OUT), .CAPACITY_OUT(CAPACITY_OUT), .BUSY_OUT(BUSY_OUT));

/* File: chsg_geometry_test.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, a); end end
module chsg_geometry_test;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic [31:0]          total = 32'h0;
	logic                 stb;
	chsg_pkg::chsg_init_t prm;
	chsg_pkg::chsg_geom_t def_g;
	chsg_pkg::chsg_geom_t cur_g;
	logic [15:0]          w53;
	logic [31:0]          cap;
	logic                 busy;
	int                   err_count = 0;
	int                   checks = 0;
	// corners first: widest, smallest, then three illegal modes
	logic [4:0]           hs [5] = '{5'h10, 5'h01, 5'h00, 5'h11, 5'h03};
	logic [7:0]           ss [5] = '{8'hff, 8'h01, 8'h05, 8'h01, 8'h00};
	always #5 mclk = ~mclk;
	chsg_geometry dut (.MCLK_IN(mclk), .SYS_RST_IN(rst),
		.TOTAL_SECTORS_IN(total), .INIT_STB_IN(stb), .INIT_PARAMS_IN(prm),
		.DEF_GEOM_OUT(def_g), .CUR_GEOM_OUT(cur_g), .WORD53_OUT(w53),
		.CAPACITY_OUT(cap), .BUSY_OUT(busy));
	chsg_host host (.clk_in(mclk), .busy_in(busy), .stb_out(stb),
		.params_out(prm));
	// truncated quotient, clamped at the given limit
	function automatic logic [15:0] cyl(logic [15:0] h, s, lim);
		logic [31:0] q;
		q = total / (h * s);
		return (q > {16'h0000, lim}) ? lim : q[15:0];
	endfunction : cyl
	task automatic wait_idle;
		int n;
		n = 0;
		@(negedge mclk);
		while (busy !== 1'b0 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		`CHK("busy", 1'b0, busy)
	endtask : wait_idle
	task automatic check_cur(input logic [15:0] h, s, lim, input logic ok);
		logic [15:0] c;
		logic [31:0] p;
		c = ok ? cyl(h, s, lim) : 16'h0000;
		p = c * h * s;
		`CHK("word53", {15'h0000, ok}, w53)
		`CHK("cylinders", c, cur_g.cylinders)
		`CHK("heads", ok ? h : 16'h0000, cur_g.heads)
		`CHK("sectors", ok ? s : 16'h0000, cur_g.sectors)
		`CHK("capacity", p, cap)
	endtask : check_cur
	// reset with a new total, then defaults and current words
	task automatic do_reset(input logic [31:0] t);
		logic [15:0] lim;
		@(negedge mclk);
		rst = 1'b1;
		total = t;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		wait_idle;
		lim = (t <= chsg_pkg::SMALL_SECTORS) ? 16'h0400 : 16'h3fff;
		`CHK("def heads", 16'h0010, def_g.heads)
		`CHK("def sectors", 16'h003f, def_g.sectors)
		`CHK("def cyl", cyl(16'h0010, 16'h003f, lim), def_g.cylinders)
		check_cur(16'h0010, 16'h003f, lim, 1'b1);
		$display("test reset done");
	endtask : do_reset
	// illegal modes sit between legal ones, so recovery is seen too
	task automatic run_inits;
		logic [4:0] h;
		logic [7:0] s;
		for (int i = 0; i < 10; i++) begin
			h = (i < 5) ? hs[i] : 5'(1 + $urandom % 16);
			s = (i < 5) ? ss[i] : 8'(1 + $urandom % 255);
			host.issue(h, s);
			wait_idle;
			check_cur({11'h000, h}, {8'h00, s}, 16'hffff,
				h != 5'h00 && h <= 5'h10 && s != 8'h00);
		end
		$display("test init done");
	endtask : run_inits
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	// small-threshold boundary, a random large device, then a full-scale
	// total so the default cylinder clamp is really tripped
	initial begin
		void'($urandom(42));
		do_reset(chsg_pkg::SMALL_SECTORS);
		run_inits;
		do_reset(32'h000fc001 + $urandom % 32'h00ec3fff);
		run_inits;
		do_reset(32'hffffffff);
		run_inits;
		give_verdict;
	end
	// well beyond the expected run of about 930 cycles
	initial begin
		#200000;
		err_count++;
		give_verdict;
	end
endmodule : chsg_geometry_test

/* File: chsg_host.sv */
`timescale 1ns/10ps
// host side: sends init commands only while the device is idle
module chsg_host (
	input  wire logic            clk_in,
	input  wire logic            busy_in,
	output logic                 stb_out,
	output chsg_pkg::chsg_init_t params_out
);
	// idle lines start as all ones, never valid; after a strobe they carry the inverse, which can be legal
	initial begin
		stb_out = 1'b0;
		params_out = '1;
	end
	// one-cycle strobe launched off the falling edge
	task automatic issue(input logic [4:0] h, input logic [7:0] s);
		@(negedge clk_in);
		while (busy_in) @(negedge clk_in);
		stb_out = 1'b1;
		params_out = {h, s};
		@(negedge clk_in);
		stb_out = 1'b0;
		params_out = ~params_out;
	endtask : issue
endmodule : chsg_host

/* File: chsg_pkg.sv */
package chsg_pkg;
	// capacity threshold of the small class, in sectors
	localparam logic [31:0] SMALL_SECTORS   = 32'h000fc000;
	localparam logic [15:0] SMALL_CYL_MAX   = 16'h0400;
	localparam logic [15:0] DEF_HEADS       = 16'h0010;
	localparam logic [15:0] DEF_SECTORS     = 16'h003f;
	localparam logic [15:0] CAP_FEW_HEADS   = 16'hffff;
	localparam logic [15:0] CAP_MID_HEADS   = 16'h7fff;
	localparam logic [15:0] CAP_MANY_HEADS  = 16'h3fff;
	localparam logic [15:0] HEADS_FEW_LIM   = 16'h0004;
	localparam logic [15:0] HEADS_MID_LIM   = 16'h0008;
	localparam logic [4:0]  CUR_HEADS_MAX   = 5'h10;
	localparam logic [15:0] WORD_MAX        = 16'hffff;
	localparam logic [5:0]  DIV_STEPS       = 6'h20;

	typedef struct packed {
		logic [15:0] cylinders;
		logic [15:0] heads;
		logic [15:0] sectors;
	} chsg_geom_t;

	typedef struct packed {
		logic [4:0] heads;
		logic [7:0] sectors;
	} chsg_init_t;
endpackage : chsg_pkg
